// [dv/oacg_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Unified code, data and peripheral memory
// ----------------------------------------
// Contents follow the address, so a wrong address yields a wrong word
module oacg_mem_model
(
    // Lookup
    input wire logic [15:0] mem_addr,
    output logic [15:0] mem_word
);
    // Zero-wait answer; the core sees it through the word software loads
    assign mem_word = {mem_addr[7:0] ^ 8'hA5, mem_addr[15:8] ^ 8'h3C};
endmodule

`default_nettype wire

// [dv/oacg_props.sv]
`timescale 1ns/1ns
`default_nettype none
`include "oacg_defines.vh"

// Watches the register port and shadows the last operation
module oacg_props
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata
);
    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    logic [15:0] ins_r; // Last instruction word
    logic [15:0] ext0_r; // Older extension word
    logic [15:0] ext1_r; // Newer extension word
    logic [3:0] age_r; // Cycles since go, saturating
    logic ran_r; // Go seen since the last instruction write
    wire logic wr = psel && penable && pwrite;
    wire logic rd = psel && penable && !pwrite;
    wire logic go = wr && (paddr == `OACG_A_CTRL) && pwdata[0];
    wire logic [3:0] src = ins_r[11:8];
    wire logic [1:0] sm = ins_r[5:4];
    // Results are trusted only once the two-stage walk is surely over
    wire logic done = ran_r && (age_r > 4'h2);
    wire logic idx = (sm == `OACG_AS_IDX) && (src != `OACG_IDX_CG);
    wire logic imm = (sm == `OACG_AS_INC) && (src == `OACG_IDX_PC);
    wire logic [1:0] n_ext = {1'b0, idx || imm} + {1'b0, ins_r[7]};
    wire logic [15:0] k_cg = (sm == 2'h0) ? `OACG_K_ZERO : (sm == 2'h1) ? `OACG_K_ONE :
        (sm == 2'h2) ? `OACG_K_TWO : `OACG_K_ALL1;

    // Instruction shadow
    always_ff @(posedge core_clk)
        if (!rst_b)
            ins_r <= 16'h0000;
        else if (wr && paddr == `OACG_A_INSTR)
            ins_r <= pwdata[15:0];
    // A new instruction voids the old result
    always_ff @(posedge core_clk)
        if (!rst_b || (wr && paddr == `OACG_A_INSTR))
            ran_r <= 1'b0;
        else if (go)
            ran_r <= 1'b1;
    // Age stops at its top so it never wraps back to busy
    always_ff @(posedge core_clk)
        if (!rst_b || go)
            age_r <= 4'h0;
        else if (age_r != 4'hF)
            age_r <= age_r + 4'h1;
    // Extension words shift in like the design's pair
    always_ff @(posedge core_clk)
        if (!rst_b)
            ext0_r <= 16'h0000;
        else if (wr && paddr == `OACG_A_EXT)
            ext0_r <= ext1_r;
    always_ff @(posedge core_clk)
        if (!rst_b)
            ext1_r <= 16'h0000;
        else if (wr && paddr == `OACG_A_EXT)
            ext1_r <= pwdata[15:0];

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_result(logic [7:0] a);
        rd && paddr == a && done;
    endsequence
    property p_ready_now;
        s_setup |=> pready;
    endproperty
    a_ready_now: assert property (p_ready_now) else $error("access not answered at once");
    property p_err_map;
        psel && penable |-> pslverr == (paddr > `OACG_A_MEMRD || paddr[1:0] != 2'h0);
    endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    property p_zero_hole;
        rd && paddr > `OACG_A_MEMRD |-> prdata == 32'h00000000;
    endproperty
    a_zero_hole: assert property (p_zero_hole) else $error("unmapped read not zero");
    property p_busy_end;
        s_result(`OACG_A_STAT) |-> !prdata[0];
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("operation still busy");
    property p_cg_val;
        s_result(`OACG_A_OPND) ##0 (src == `OACG_IDX_CG) |-> prdata[15:0] == k_cg;
    endproperty
    a_cg_val: assert property (p_cg_val) else $error("zero register constant wrong");
    property p_sr_val;
        s_result(`OACG_A_OPND) ##0 (src == `OACG_IDX_SR && sm[1])
            |-> prdata[15:0] == (sm[0] ? `OACG_K_EIGHT : `OACG_K_FOUR);
    endproperty
    a_sr_val: assert property (p_sr_val) else $error("status index constant wrong");
    property p_ext_cnt;
        s_result(`OACG_A_STAT) |-> prdata[3:2] == n_ext;
    endproperty
    a_ext_cnt: assert property (p_ext_cnt) else $error("extension word count wrong");
    property p_abs_ea;
        s_result(`OACG_A_EA) ##0 (src == `OACG_IDX_SR && sm == `OACG_AS_IDX && !ins_r[7])
            |-> prdata[15:0] == ext0_r;
    endproperty
    a_abs_ea: assert property (p_abs_ea) else $error("absolute address wrong");
endmodule

bind oacg_top oacg_props u_props
(
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata)
);

`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "oacg_defines.vh"

module tb;
    // ----------------------------------------
    // Clock, reset and bus
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    wire logic pready;
    wire logic pslverr;
    wire logic [31:0] prdata;
    logic [15:0] mem_a = 16'h0000; // Address asked of memory
    wire logic [15:0] mem_w; // Word memory holds there
    logic [15:0] rdat; // Data of the last transfer
    logic rerr; // Error flag of the last transfer
    int n_mismatch = 0;
    int n_compared = 0;

    always #5 core_clk = ~core_clk;

    oacg_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata));
    oacg_mem_model mem_u (.mem_addr(mem_a), .mem_word(mem_w));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    // Select stays up between transfers so back-to-back setups never double-drive it
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // Data and error are taken at the edge that samples pready high
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            n_mismatch++;
        rdat = prdata[15:0];
        rerr = pslverr;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 16'h0000);
    endtask
    task automatic setr(input logic [3:0] i, input logic [15:0] v);
        wr(`OACG_A_REGW, {12'h000, i});
        wr(`OACG_A_REGD, v);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chkr(input logic [3:0] i, input logic [15:0] exp);
        wr(`OACG_A_REGW, {12'h000, i});
        rd(`OACG_A_REGD);
        chk("register", exp, rdat);
    endtask
    function automatic logic [15:0] enc(logic [3:0] s, logic [1:0] m, logic ad, logic [3:0] d);
        return {4'h0, s, ad, 1'b0, m, d};
    endfunction
    // One operation: extension words, memory word, instruction, go, wait till idle
    task automatic run(input logic [15:0] ins, input logic [1:0] fb, input logic [15:0] x0,
        input logic [15:0] x1, input logic [15:0] ea, input logic [15:0] step);
        logic [15:0] pc0;
        int n;
        mem_a = ea;
        rd(`OACG_A_PC);
        pc0 = rdat;
        wr(`OACG_A_EXT, x0);
        wr(`OACG_A_EXT, x1);
        wr(`OACG_A_MEMRD, mem_w);
        wr(`OACG_A_INSTR, ins);
        wr(`OACG_A_CTRL, {13'h0000, fb, 1'b1});
        n = 0;
        do
        begin
            rd(`OACG_A_STAT);
            n++;
        end
        while (rdat[0] !== 1'b0 && n < 20);
        chk("busy", 16'h0000, {15'h0000, rdat[0]});
        rd(`OACG_A_PC);
        chk("pc step", pc0 + step, rdat);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_move;
        setr(4'hA, 16'hA023);
        setr(4'hB, 16'hFA15);
        run(enc(4'hA, 2'h0, 1'b0, 4'hB), 2'h0, 16'h0, 16'h0, 16'h0, 16'h2);
        chkr(4'hB, 16'hA023);
        chkr(4'hA, 16'hA023);
        rd(`OACG_A_SR);
        chk("flags", 16'h0000, rdat);
    endtask
    // Every constant, then a write aimed at the zero register must not stick
    task automatic s_const;
        logic [3:0] sr[6] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2};
        logic [15:0] kv[6] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF, 16'h0004, 16'h0008};
        for (int i = 0; i < 6; i++)
        begin
            setr(4'h5, 16'h1234);
            run(enc(sr[i], 2'(i % 4 + i / 4 * 2), 1'b0, 4'h5), 2'h0, 16'h0, 16'h0, 16'h0,
                16'h2);
            chkr(4'h5, kv[i]);
            rd(`OACG_A_OPND);
            chk("operand", kv[i], rdat);
            rd(`OACG_A_STAT);
            chk("stat", 16'h0000, rdat);
        end
        run(enc(4'h5, 2'h0, 1'b0, 4'h3), 2'h0, 16'h0, 16'h0, 16'h0, 16'h2);
        run(enc(4'h3, 2'h0, 1'b0, 4'h6), 2'h0, 16'h0, 16'h0, 16'h0, 16'h2);
        chkr(4'h6, 16'h0000);
    endtask
    // Byte moves: upper byte cleared, flags from the low byte only
    task automatic s_byte;
        setr(4'h6, 16'h1280);
        run(enc(4'h6, 2'h0, 1'b0, 4'h7), 2'h3, 16'h0, 16'h0, 16'h0, 16'h2);
        chkr(4'h7, 16'h0080);
        rd(`OACG_A_SR);
        chk("flags", 16'h0005, rdat);
        setr(4'h6, 16'h1200);
        run(enc(4'h6, 2'h0, 1'b0, 4'h7), 2'h3, 16'h0, 16'h0, 16'h0, 16'h2);
        rd(`OACG_A_SR);
        chk("flags", 16'h0002, rdat);
        setr(4'h6, 16'h8000);
        run(enc(4'h6, 2'h0, 1'b0, 4'h7), 2'h0, 16'h0, 16'h0, 16'h0, 16'h2);
        rd(`OACG_A_SR);
        chk("flags", 16'h0002, rdat);
        setr(4'h5, 16'h0104);
        run(enc(4'h5, 2'h0, 1'b0, 4'h2), 2'h2, 16'h0, 16'h0, 16'h0, 16'h2);
        rd(`OACG_A_SR);
        chk("status", 16'h0104, rdat);
    endtask
    // Memory modes, immediate, and a two-extension pairing
    task automatic s_modes;
        setr(4'h5, 16'h1080);
        run(enc(4'h5, 2'h1, 1'b0, 4'h7), 2'h0, 16'h2, 16'h2, 16'h1082, 16'h4);
        rd(`OACG_A_EA);
        chk("address", 16'h1082, rdat);
        chkr(4'h7, mem_w);
        run(enc(4'h2, 2'h1, 1'b0, 4'h7), 2'h0, 16'h200, 16'h200, 16'h200, 16'h4);
        rd(`OACG_A_EA);
        chk("address", 16'h0200, rdat);
        wr(`OACG_A_PC, 16'h0100);
        run(enc(4'h0, 2'h1, 1'b0, 4'h7), 2'h0, 16'h20, 16'h20, 16'h120, 16'h4);
        rd(`OACG_A_EA);
        chk("address", 16'h0120, rdat);
        run(enc(4'h5, 2'h2, 1'b0, 4'h7), 2'h0, 16'h0, 16'h0, 16'h1080, 16'h2);
        rd(`OACG_A_EA);
        chk("address", 16'h1080, rdat);
        chkr(4'h5, 16'h1080);
        run(enc(4'h5, 2'h3, 1'b0, 4'h7), 2'h0, 16'h0, 16'h0, 16'h1080, 16'h2);
        chkr(4'h5, 16'h1082);
        run(enc(4'h5, 2'h3, 1'b0, 4'h7), 2'h1, 16'h0, 16'h0, 16'h1082, 16'h2);
        chkr(4'h5, 16'h1083);
        run(enc(4'h0, 2'h3, 1'b0, 4'h7), 2'h0, 16'hBEEF, 16'hBEEF, 16'h0, 16'h4);
        rd(`OACG_A_OPND);
        chk("operand", 16'hBEEF, rdat);
        run(enc(4'h5, 2'h1, 1'b1, 4'h6), 2'h0, 16'h2, 16'h6, 16'h1085, 16'h6);
        rd(`OACG_A_STAT);
        chk("stat", 16'h0008, rdat);
        rd(8'h30);
        chk("hole error", 16'h0001, {15'h0000, rerr});
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic summarize;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(`OACG_A_PC);
        chk("pc", `OACG_PC_RST, rdat);
        s_move();
        s_const();
        s_byte();
        s_modes();
        psel <= 1'b0;
        @(posedge core_clk);
        summarize();
    end
    // The whole run needs well under a thousand cycles; far beyond that is a hang
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
endmodule

`default_nettype wire

// [inc/oacg_defines.vh]
`ifndef OACG_DEFINES_VH
`define OACG_DEFINES_VH

// ----------------------------------------------------------------
// Register indices with dedicated roles
// ----------------------------------------------------------------
`define OACG_IDX_PC 4'h0
`define OACG_IDX_SP 4'h1
`define OACG_IDX_SR 4'h2
`define OACG_IDX_CG 4'h3

// ----------------------------------------------------------------
// Source mode field codes
// ----------------------------------------------------------------
`define OACG_AS_REG 2'h0
`define OACG_AS_IDX 2'h1
`define OACG_AS_IND 2'h2
`define OACG_AS_INC 2'h3

// ----------------------------------------------------------------
// Generated constants
// ----------------------------------------------------------------
`define OACG_K_ZERO 16'h0000
`define OACG_K_ONE 16'h0001
`define OACG_K_TWO 16'h0002
`define OACG_K_FOUR 16'h0004
`define OACG_K_EIGHT 16'h0008
`define OACG_K_ALL1 16'hFFFF

// ----------------------------------------------------------------
// Status flag positions and reset values
// ----------------------------------------------------------------
`define OACG_SR_C 0
`define OACG_SR_Z 1
`define OACG_SR_N 2
`define OACG_SR_V 8
`define OACG_SR_RST 16'h0000
`define OACG_PC_RST 16'h0000
`define OACG_PC_STEP 16'h0002

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define OACG_A_INSTR 8'h00
`define OACG_A_EXT 8'h04
`define OACG_A_CTRL 8'h08
`define OACG_A_STAT 8'h0C
`define OACG_A_PC 8'h10
`define OACG_A_SR 8'h14
`define OACG_A_EA 8'h18
`define OACG_A_OPND 8'h1C
`define OACG_A_REGW 8'h20
`define OACG_A_REGD 8'h24
`define OACG_A_MEMRD 8'h28

// CTRL bits
`define OACG_CTL_GO 0
`define OACG_CTL_BYTE 1
`define OACG_CTL_FLAGS 2

`endif

// [verilog/oacg_const_gen.v]
`timescale 1ns/1ns
`default_nettype none
`include "oacg_defines.vh"

// Constant generator: fixed values for the status and zero registers
module oacg_const_gen
(
    // Operand selection
    input wire [3:0] src_reg,
    input wire [1:0] src_mode,
    // Result
    output reg is_const,
    output reg abs_mode,
    output reg [15:0] const_val
);

    // ----------------------------------------------------------------
    // Decode table
    // ----------------------------------------------------------------
    // Pure combinational; constants need no extension word, absolute mode still does
    always @*
    begin
        is_const = 1'b0;
        abs_mode = 1'b0;
        const_val = `OACG_K_ZERO;
        if (src_reg == `OACG_IDX_SR)
        begin
            case (src_mode)
                `OACG_AS_IDX:
                begin
                    // Base zero turns indexed into absolute
                    abs_mode = 1'b1;
                end
                `OACG_AS_IND:
                begin
                    is_const = 1'b1;
                    const_val = `OACG_K_FOUR;
                end
                `OACG_AS_INC:
                begin
                    is_const = 1'b1;
                    const_val = `OACG_K_EIGHT;
                end
                default:
                begin
                    // Register mode reaches the real status register
                    is_const = 1'b0;
                end
            endcase
        end
        else if (src_reg == `OACG_IDX_CG)
        begin
            is_const = 1'b1;
            case (src_mode)
                `OACG_AS_REG: const_val = `OACG_K_ZERO;
                `OACG_AS_IDX: const_val = `OACG_K_ONE;
                `OACG_AS_IND: const_val = `OACG_K_TWO;
                default: const_val = `OACG_K_ALL1;
            endcase
        end
    end

endmodule

`default_nettype wire

// [verilog/oacg_top.v]
// What this block does
// - Flags change only for flag-affecting instructions and for register-mode writes to the status register
// - Status index: mode 01 absolute, 10 four, 11 eight
// - Zero register gives 0, 1, 2, all-ones
// - Constants need no extra code fetch
// - Status register is an operand only in register mode
// - Constant registers are source-only in constant mode
// - Two-bit source mode, one-bit destination mode, full space
// - Indexed address is register plus extension offset
// - Symbolic is indexed on the program counter
// - Absolute takes the extension word as address
// - Mode 10 indirect, 11 indirect then increment
// - Any source and destination mode pairing accepted
// - Register move copies source, program counter plus 2
// - Byte results written to registers clear upper byte
// - Byte operations derive flags from the low byte
// - Zero register mode 00 yields zero, one word
// - Program counter advances by 2, 4 or 6, even
`timescale 1ns/1ns
`default_nettype none
`include "oacg_defines.vh"

module oacg_top
(
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata
);

    // ----------------------------------------------------------------
    // State and storage
    // ----------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_SRC = 3'b010;
    localparam ST_DST = 3'b100;

    reg [15:0] regs_r [0:15]; // Register file; index 0 is the program counter
    reg [15:0] instr_r; // Instruction word: src[11:8] as[5:4] ad[7] dst[3:0]
    reg [15:0] ext_r [0:1]; // Extension words, source first
    reg [15:0] memrd_r; // Memory word returned for the current operand
    reg [2:0] state_r;
    reg busy_r;
    reg byte_r;
    reg flags_r;
    reg [15:0] ea_r; // Last effective address
    reg [15:0] opnd_r; // Resolved source operand
    reg [15:0] sr_r; // Status register
    reg [3:0] regw_idx_r; // Register selected for debug read/write
    reg [1:0] nwords_r; // Extension words consumed by the last instruction

    // Instruction fields
    wire [3:0] src_reg = instr_r[11:8];
    wire [1:0] src_mode = instr_r[5:4];
    wire dst_mode = instr_r[7];
    wire [3:0] dst_reg = instr_r[3:0];

    wire cg_const;
    wire cg_abs;
    wire [15:0] cg_val;

    oacg_const_gen u_cg
    (
        .src_reg(src_reg),
        .src_mode(src_mode),
        .is_const(cg_const),
        .abs_mode(cg_abs),
        .const_val(cg_val)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Source needs an extension word only in indexed mode or as immediate, never for a constant
    function src_ext;
        input [1:0] mode;
        input is_k;
        input [3:0] rg;
        begin
            src_ext = !is_k && ((mode == `OACG_AS_IDX) ||
                ((mode == `OACG_AS_INC) && (rg == `OACG_IDX_PC)));
        end
    endfunction

    // Byte results keep only the low byte
    function [15:0] size_fix;
        input [15:0] v;
        input b;
        begin
            size_fix = b ? {8'h00, v[7:0]} : v;
        end
    endfunction

    wire s_ext = src_ext(src_mode, cg_const, src_reg);
    wire d_ext = dst_mode;
    wire [15:0] inc_step = byte_r ? `OACG_K_ONE : `OACG_PC_STEP;

    // ----------------------------------------------------------------
    // Source operand resolution
    // ----------------------------------------------------------------
    reg [15:0] src_ea;
    reg [15:0] src_val;
    always @*
    begin
        src_ea = `OACG_K_ZERO;
        src_val = `OACG_K_ZERO;
        if (cg_const)
        begin
            src_val = cg_val;
        end
        else if (cg_abs)
        begin
            src_ea = ext_r[0];
            src_val = memrd_r;
        end
        else
        begin
            case (src_mode)
                `OACG_AS_REG: src_val = (src_reg == `OACG_IDX_SR) ? sr_r : regs_r[src_reg];
                // Program counter base gives symbolic mode for free
                `OACG_AS_IDX:
                begin
                    src_ea = regs_r[src_reg] + ext_r[0];
                    src_val = memrd_r;
                end
                `OACG_AS_IND:
                begin
                    src_ea = regs_r[src_reg];
                    src_val = memrd_r;
                end
                default:
                begin
                    // Immediate: word after the opcode is the operand
                    if (src_reg == `OACG_IDX_PC)
                    begin
                        src_val = ext_r[0];
                        src_ea = regs_r[`OACG_IDX_PC] + `OACG_PC_STEP;
                    end
                    else
                    begin
                        src_ea = regs_r[src_reg];
                        src_val = memrd_r;
                    end
                end
            endcase
        end
    end

    // Destination address for indexed/symbolic/absolute
    wire [15:0] dst_base = (dst_reg == `OACG_IDX_SR) ? `OACG_K_ZERO : regs_r[dst_reg];
    wire [15:0] dst_ea = dst_base + (s_ext ? ext_r[1] : ext_r[0]);
    wire [15:0] res_val = size_fix(src_val, byte_r);

    // Flags from the sized result
    wire res_neg = byte_r ? res_val[7] : res_val[15];
    wire res_zero = byte_r ? (res_val[7:0] == 8'h00) : (res_val == `OACG_K_ZERO);

    // ----------------------------------------------------------------
    // APB decode; every access finishes in its first access cycle
    // ----------------------------------------------------------------
    wire apb_wr = psel && penable && pwrite;
    wire apb_rd_hit = (paddr[1:0] == 2'b00) && (paddr <= `OACG_A_MEMRD);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_rd_hit;

    // ----------------------------------------------------------------
    // Execution sequencer
    // ----------------------------------------------------------------
    // One cycle to resolve the source, one to retire the destination
    integer i;
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            for (i = 0; i < 16; i = i + 1)
                regs_r[i] <= 16'h0000;
            instr_r <= 16'h0000;
            ext_r[0] <= 16'h0000;
            ext_r[1] <= 16'h0000;
            memrd_r <= 16'h0000;
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            byte_r <= 1'b0;
            flags_r <= 1'b0;
            ea_r <= 16'h0000;
            opnd_r <= 16'h0000;
            sr_r <= `OACG_SR_RST;
            regw_idx_r <= 4'h0;
            nwords_r <= 2'h0;
        end
        else
        begin
            // Software loads while idle; writes during execution are dropped
            if (apb_wr && !busy_r)
            begin
                case (paddr)
                    `OACG_A_INSTR: instr_r <= pwdata[15:0];
                    `OACG_A_EXT:
                    begin
                        // Two-deep shift so the source word lands first
                        ext_r[0] <= ext_r[1];
                        ext_r[1] <= pwdata[15:0];
                    end
                    `OACG_A_MEMRD: memrd_r <= pwdata[15:0];
                    `OACG_A_PC: regs_r[`OACG_IDX_PC] <= {pwdata[15:1], 1'b0};
                    `OACG_A_SR: sr_r <= pwdata[15:0];
                    `OACG_A_REGW: regw_idx_r <= pwdata[3:0];
                    `OACG_A_REGD:
                    begin
                        // Constant register holds no storage
                        if (regw_idx_r != `OACG_IDX_CG && regw_idx_r != `OACG_IDX_SR)
                            regs_r[regw_idx_r] <= pwdata[15:0];
                    end
                    `OACG_A_CTRL:
                    begin
                        byte_r <= pwdata[`OACG_CTL_BYTE];
                        flags_r <= pwdata[`OACG_CTL_FLAGS];
                        if (pwdata[`OACG_CTL_GO])
                        begin
                            busy_r <= 1'b1;
                            state_r <= ST_SRC;
                        end
                    end
                    default:
                    begin
                        busy_r <= busy_r;
                    end
                endcase
            end
            case (state_r)
                ST_IDLE:
                begin
                    // Go is taken by the port decode above; no assignment here to undo it
                end
                ST_SRC:
                begin
                    ea_r <= src_ea;
                    opnd_r <= res_val;
                    // Post-increment of the pointer register
                    if (!cg_const && !cg_abs && src_mode == `OACG_AS_INC &&
                        src_reg != `OACG_IDX_PC)
                        regs_r[src_reg] <= regs_r[src_reg] + inc_step;
                    state_r <= ST_DST;
                end
                ST_DST:
                begin
                    if (d_ext)
                        ea_r <= dst_ea;
                    else if (dst_reg == `OACG_IDX_SR)
                        sr_r <= res_val;
                    else if (dst_reg != `OACG_IDX_PC && dst_reg != `OACG_IDX_CG)
                        regs_r[dst_reg] <= res_val;
                    // Flag-affecting instructions touch V N Z C unless the status register is the register-mode destination
                    if (flags_r && !(!d_ext && dst_reg == `OACG_IDX_SR))
                    begin
                        sr_r[`OACG_SR_N] <= res_neg;
                        sr_r[`OACG_SR_Z] <= res_zero;
                        sr_r[`OACG_SR_C] <= !res_zero;
                        sr_r[`OACG_SR_V] <= 1'b0;
                    end
                    // Opcode plus extension words, always even
                    regs_r[`OACG_IDX_PC] <= regs_r[`OACG_IDX_PC] + `OACG_PC_STEP +
                        (s_ext ? `OACG_PC_STEP : `OACG_K_ZERO) +
                        (d_ext ? `OACG_PC_STEP : `OACG_K_ZERO);
                    nwords_r <= {1'b0, s_ext} + {1'b0, d_ext};
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read data mux
    // ----------------------------------------------------------------
    always @*
    begin
        case (paddr)
            `OACG_A_INSTR: prdata = {16'h0000, instr_r};
            `OACG_A_EXT: prdata = {ext_r[1], ext_r[0]};
            `OACG_A_CTRL: prdata = {29'h0, flags_r, byte_r, busy_r};
            `OACG_A_STAT: prdata = {28'h0, nwords_r, 1'b0, busy_r};
            `OACG_A_PC: prdata = {16'h0000, regs_r[`OACG_IDX_PC]};
            `OACG_A_SR: prdata = {16'h0000, sr_r};
            `OACG_A_EA: prdata = {16'h0000, ea_r};
            `OACG_A_OPND: prdata = {16'h0000, opnd_r};
            `OACG_A_REGW: prdata = {28'h0, regw_idx_r};
            `OACG_A_REGD: prdata = {16'h0000, regs_r[regw_idx_r]};
            `OACG_A_MEMRD: prdata = {16'h0000, memrd_r};
            default: prdata = 32'h0000_0000;
        endcase
    end

endmodule

`default_nettype wire
